// File: verilog/crg_run_gate.v
`timescale 1ns/10ps
`include "crg_defines.vh"
module crg_run_gate #(
  parameter CW = 32,
  parameter TW = 32
) (
  input  wire          clk,
  input  wire          nrst,
  input  wire          start_in,
  input  wire          stop_in,
  input  wire          gate_in,
  input  wire          limit_ch_tick,
  input  wire [3:0]    reg_addr,
  input  wire [31:0]   reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [31:0]   reg_rdata,
  output reg           run_out,
  output reg           count_en,
  output reg  [1:0]    row_upper_sel,
  output reg  [1:0]    row_lower_sel
);

  // ****************************************
  // reset release
  // ****************************************
  reg rst_s1_r;
  reg rst_n_r;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ****************************************
  // input synchronisers and qualification
  // ****************************************
  wire start_s;
  wire stop_s;
  wire gate_s;

  // undriven start/stop resolve low and gate high at the pad pulls
  crg_sync2 #(.RST_VAL(1'b0)) u_sync_start (
    .clk   (clk),
    .rst_n (rst_n_r),
    .d     (start_in),
    .q     (start_s)
  );
  crg_sync2 #(.RST_VAL(1'b0)) u_sync_stop (
    .clk   (clk),
    .rst_n (rst_n_r),
    .d     (stop_in),
    .q     (stop_s)
  );
  crg_sync2 #(.RST_VAL(1'b1)) u_sync_gate (
    .clk   (clk),
    .rst_n (rst_n_r),
    .d     (gate_in),
    .q     (gate_s)
  );

  reg  [3:0] polarity_switch_bank_r;
  wire       start_act = start_s ~^ polarity_switch_bank_r[`CRG_POL_START];
  wire       stop_act  = stop_s  ~^ polarity_switch_bank_r[`CRG_POL_STOP];
  wire       gate_act  = gate_s  ~^ polarity_switch_bank_r[`CRG_POL_GATE];
  wire       start_edge;
  wire       stop_edge;

  crg_edge u_edge_start (
    .clk   (clk),
    .rst_n (rst_n_r),
    .lvl   (start_act),
    .rise  (start_edge)
  );
  crg_edge u_edge_stop (
    .clk   (clk),
    .rst_n (rst_n_r),
    .lvl   (stop_act),
    .rise  (stop_edge)
  );

  // ****************************************
  // software registers
  // ****************************************
  reg  [1:0]    stop_mode_r;
  reg  [CW-1:0] preset_count_r;
  reg  [TW-1:0] preset_time_r;
  reg  [CW-1:0] limit_count_r;
  reg  [TW-1:0] elapsed_r;
  reg  [7:0]    tick_cnt_r;
  reg           started_r;
  reg           limit_hit_r;

  wire wr_ctrl  = reg_wr && (reg_addr == `CRG_REG_CTRL);
  wire sw_start = wr_ctrl && reg_wdata[`CRG_CTRL_START];
  wire sw_stop  = wr_ctrl && reg_wdata[`CRG_CTRL_STOP];
  wire sw_clear = wr_ctrl && reg_wdata[`CRG_CTRL_CLEAR];
  wire [1:0] mode_wr = reg_wdata[`CRG_CTRL_MODE_HI:`CRG_CTRL_MODE_LO];

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stop_mode_r            <= `CRG_MODE_NONE;
      polarity_switch_bank_r <= `CRG_POL_RESET;
      preset_count_r         <= {CW{1'b0}};
      preset_time_r          <= {TW{1'b0}};
      row_upper_sel          <= `CRG_SRC_COUNT;
      row_lower_sel          <= `CRG_SRC_TIMER;
    end else if (reg_wr) begin
      case (reg_addr)
        `CRG_REG_CTRL:   stop_mode_r <= mode_wr;
        `CRG_REG_POL:    polarity_switch_bank_r <= reg_wdata[3:0];
        `CRG_REG_PCOUNT: preset_count_r <= reg_wdata[CW-1:0];
        `CRG_REG_PTIME:  preset_time_r <= reg_wdata[TW-1:0];
        `CRG_REG_DISP: begin
          row_upper_sel <= reg_wdata[1:0];
          row_lower_sel <= reg_wdata[3:2];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // run state
  // ****************************************
  wire limit_mode  = (stop_mode_r == `CRG_MODE_COUNT) || (stop_mode_r == `CRG_MODE_TIMER);
  wire cnt_reach   = (stop_mode_r == `CRG_MODE_COUNT) && (limit_count_r >= preset_count_r);
  wire tim_reach   = (stop_mode_r == `CRG_MODE_TIMER) && (elapsed_r >= preset_time_r);
  wire reach       = cnt_reach || tim_reach;
  wire any_stop    = stop_edge || sw_stop;
  wire any_start   = start_edge || sw_start;
  wire locked      = limit_mode && (limit_hit_r || reach);
  wire active      = started_r && gate_act;
  wire tick        = (tick_cnt_r == (`CRG_TICK_CYC - 1));

  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      started_r   <= 1'b0;
      limit_hit_r <= 1'b0;
    end else begin
      if (any_stop) begin
        started_r <= 1'b0;
      end else if (started_r && reach) begin
        started_r <= 1'b0;
      end else if (any_start && !locked) begin
        started_r <= 1'b1;
      end
      // a limit hit in the clear cycle still locks: the set wins
      if (started_r && reach) begin
        limit_hit_r <= 1'b1;
      end else if (sw_clear) begin
        limit_hit_r <= 1'b0;
      end
    end
  end

  // counters local to the limit test; the unit's channel counters live elsewhere
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      limit_count_r <= {CW{1'b0}};
      elapsed_r     <= {TW{1'b0}};
      tick_cnt_r    <= 8'h00;
    end else if (sw_clear) begin
      limit_count_r <= {CW{1'b0}};
      elapsed_r     <= {TW{1'b0}};
      tick_cnt_r    <= 8'h00;
    end else if (active) begin
      if (limit_ch_tick) begin
        limit_count_r <= limit_count_r + {{(CW-1){1'b0}}, 1'b1};
      end
      if (tick) begin
        tick_cnt_r <= 8'h00;
        elapsed_r  <= elapsed_r + {{(TW-1){1'b0}}, 1'b1};
      end else begin
        tick_cnt_r <= tick_cnt_r + 8'h01;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      count_en <= 1'b0;
      run_out  <= 1'b0;
    end else begin
      count_en <= active;
      run_out  <= active ~^ polarity_switch_bank_r[`CRG_POL_RUN];
    end
  end

  // ****************************************
  // read port
  // ****************************************
  reg [31:0] rd_nxt;

  function [31:0] crg_src;
    input [1:0] sel;
    input [31:0] c;
    input [31:0] t;
    input [31:0] pc;
    input [31:0] pt;
    begin
      case (sel)
        `CRG_SRC_COUNT:  crg_src = c;
        `CRG_SRC_TIMER:  crg_src = t;
        `CRG_SRC_PCOUNT: crg_src = pc;
        default:         crg_src = pt;
      endcase
    end
  endfunction

  wire [31:0] cnt32  = {{(32-CW){1'b0}}, limit_count_r};
  wire [31:0] tim32  = {{(32-TW){1'b0}}, elapsed_r};
  wire [31:0] pcnt32 = {{(32-CW){1'b0}}, preset_count_r};
  wire [31:0] ptim32 = {{(32-TW){1'b0}}, preset_time_r};

  always @* begin
    rd_nxt = 32'h0000_0000;
    case (reg_addr)
      `CRG_REG_CTRL:   rd_nxt = {28'h000_0000, stop_mode_r, 2'b00};
      `CRG_REG_POL:    rd_nxt = {28'h000_0000, polarity_switch_bank_r};
      `CRG_REG_STATUS: rd_nxt = {28'h000_0000, gate_act, limit_hit_r, active, started_r};
      `CRG_REG_DISP:   rd_nxt = {28'h000_0000, row_lower_sel, row_upper_sel};
      `CRG_REG_COUNT:  rd_nxt = cnt32;
      `CRG_REG_TIMER:  rd_nxt = tim32;
      `CRG_REG_PCOUNT: rd_nxt = pcnt32;
      `CRG_REG_PTIME:  rd_nxt = ptim32;
      `CRG_REG_ROW_UP: rd_nxt = crg_src(row_upper_sel, cnt32, tim32, pcnt32, ptim32);
      `CRG_REG_ROW_LO: rd_nxt = crg_src(row_lower_sel, cnt32, tim32, pcnt32, ptim32);
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_nxt;
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: pkg/crg_defines.vh
`ifndef CRG_DEFINES_VH
`define CRG_DEFINES_VH

// register indices on the plain software port
`define CRG_REG_CTRL     4'h0
`define CRG_REG_POL      4'h1
`define CRG_REG_STATUS   4'h2
`define CRG_REG_DISP     4'h3
`define CRG_REG_COUNT    4'h4
`define CRG_REG_TIMER    4'h5
`define CRG_REG_PCOUNT   4'h6
`define CRG_REG_PTIME    4'h7
`define CRG_REG_ROW_UP   4'h8
`define CRG_REG_ROW_LO   4'h9

// ctrl register bits (write: commands are self-clearing pulses)
`define CRG_CTRL_START   0
`define CRG_CTRL_STOP    1
`define CRG_CTRL_MODE_LO 2
`define CRG_CTRL_MODE_HI 3
`define CRG_CTRL_CLEAR   4

// stop modes
`define CRG_MODE_NONE    2'h0
`define CRG_MODE_COUNT   2'h1
`define CRG_MODE_TIMER   2'h2

// polarity bank bits, 1 = active high
`define CRG_POL_START    0
`define CRG_POL_STOP     1
`define CRG_POL_GATE     2
`define CRG_POL_RUN      3
`define CRG_POL_RESET    4'hf

// status bits
`define CRG_ST_STARTED   0
`define CRG_ST_RUN       1
`define CRG_ST_LIMIT     2
`define CRG_ST_GATE      3

// display source selectors
`define CRG_SRC_COUNT    2'h0
`define CRG_SRC_TIMER    2'h1
`define CRG_SRC_PCOUNT   2'h2
`define CRG_SRC_PTIME    2'h3
`define CRG_DISP_RESET   4'h4

// timer tick: 1 us at 125 MHz
`define CRG_TICK_NS      1000
`define CRG_CLK_NS       8
`define CRG_TICK_CYC     (`CRG_TICK_NS / `CRG_CLK_NS)

`endif

// File: verilog/crg_sync2.v
`timescale 1ns/10ps
module crg_sync2 #(
  parameter RST_VAL = 1'b0
) (
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire q
);
  reg meta_r;
  reg q_r;

  // meta_r feeds only q_r
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q_r    <= RST_VAL;
    end else begin
      meta_r <= d;
      q_r    <= meta_r;
    end
  end

  assign q = q_r;
endmodule

// File: verilog/crg_edge.v
`timescale 1ns/10ps
module crg_edge (
  input  wire clk,
  input  wire rst_n,
  input  wire lvl,
  output wire rise
);
  reg prev_r;

  // reset to 1, but lvl comes from a synchroniser that resets low, so a line already active at reset still gives an edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= lvl;
    end
  end

  assign rise = lvl & ~prev_r;
endmodule

// File: sim/crg_run_gate_props.sv
`timescale 1ns/10ps
module crg_run_gate_props (
  input wire        clk,
  input wire        nrst,
  input wire        start_in,
  input wire        stop_in,
  input wire        gate_in,
  input wire [3:0]  reg_addr,
  input wire [31:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_rdata,
  input wire        run_out,
  input wire        count_en,
  input wire [1:0]  row_upper_sel,
  input wire [1:0]  row_lower_sel
);
  // ****
  // shadow of polarity and mode
  // ****
  logic [3:0] pol_r;
  logic [1:0] mode_r;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pol_r <= 4'hf;
      mode_r <= 2'h0;
    end else if (reg_wr && reg_addr == 4'h1) begin
      pol_r <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == 4'h0) begin
      mode_r <= reg_wdata[3:2];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // five samples: two sync flops plus margin
  sequence s_gate_off;
    (gate_in != pol_r[2])[*5];
  endsequence
  sequence s_start_ok;
    $rose(start_in) && pol_r[0] && !stop_in && mode_r == 2'h0 && gate_in == pol_r[2];
  endsequence
  // a polarity write right behind the edge re-reads the line, so none is wanted
  a_start_begins: assert property (s_start_ok ##1 ($stable(pol_r))[*2] |-> ##[1:3] count_en)
    else $error("start edge did not enable counting");
  a_stop_halts: assert property ($rose(stop_in) && pol_r[1] |-> ##[3:5] !count_en)
    else $error("stop edge did not halt counting");
  a_sw_stop: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata[1] |-> ##[1:3] !count_en)
    else $error("stop command did not halt counting");
  a_gate_suspend: assert property (s_gate_off |-> !count_en)
    else $error("counting while gate inactive");
  a_run_mirror: assert property ($stable(pol_r) |-> run_out == (count_en ~^ pol_r[3]))
    else $error("run output disagrees with counting state");
  a_both_edges: assert property (!count_en && $rose(start_in) && $rose(stop_in)
    && pol_r[1:0] == 2'h3 |-> (!count_en)[*6])
    else $error("start won over simultaneous stop");
  a_rows_follow: assert property (reg_wr && reg_addr == 4'h3
    |=> {row_lower_sel, row_upper_sel} == $past(reg_wdata[3:0]))
    else $error("row selectors not updated");
  a_pol_readback: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[3:0] == pol_r)
    else $error("polarity readback wrong");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule
bind crg_run_gate crg_run_gate_props crg_run_gate_props_i (
  .clk(clk), .nrst(nrst), .start_in(start_in), .stop_in(stop_in), .gate_in(gate_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .run_out(run_out), .count_en(count_en),
  .row_upper_sel(row_upper_sel), .row_lower_sel(row_lower_sel));

// File: sim/crg_ttl_src.sv
`timescale 1ns/10ps
module crg_ttl_src (
  input  wire  clk,
  output logic start_in,
  output logic stop_in,
  output logic gate_in,
  output logic limit_ch_tick
);
  // ****
  // idle levels as the pad pulls give them
  // ****
  initial begin
    start_in = 1'b0;
    stop_in = 1'b0;
    gate_in = 1'b1;
    limit_ch_tick = 1'b0;
  end
  task automatic drive(input logic [2:0] v);
    @(posedge clk);
    {gate_in, stop_in, start_in} <= v;
  endtask
  // 13 cycles keeps pulses above 100 ns
  task automatic pulse(input logic [2:0] v);
    drive(v);
    repeat (13) @(posedge clk);
    {gate_in, stop_in, start_in} <= 3'b100;
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      limit_ch_tick <= 1'b1;
      @(posedge clk);
      limit_ch_tick <= 1'b0;
    end
  endtask
endmodule

// File: sim/crg_run_gate_tb.sv
`timescale 1ns/10ps
module crg_run_gate_tb;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire         start_in, stop_in, gate_in, limit_ch_tick, run_out, count_en;
  wire  [31:0] reg_rdata;
  wire  [1:0]  row_upper_sel, row_lower_sel;
  int          fails = 0;
  int          checked = 0;
  always #4 clk = ~clk;
  crg_ttl_src crg_ttl_src_i (.clk(clk), .start_in(start_in), .stop_in(stop_in),
    .gate_in(gate_in), .limit_ch_tick(limit_ch_tick));
  crg_run_gate crg_run_gate_i (.clk(clk), .nrst(nrst), .start_in(start_in),
    .stop_in(stop_in), .gate_in(gate_in), .limit_ch_tick(limit_ch_tick),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .run_out(run_out), .count_en(count_en),
    .row_upper_sel(row_upper_sel), .row_lower_sel(row_lower_sel));
  // ****
  // helpers
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic wt(input logic v);
    for (int i = 0; i < 400 && count_en !== v; i++) @(posedge clk);
    #1 chk({31'h0, count_en}, {31'h0, v});
  endtask
  task automatic stay(input logic v);
    repeat (20) @(posedge clk);
    #1 chk({31'h0, count_en}, {31'h0, v});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    chk({run_out, count_en}, 0);
    rd(4'h1, 32'h0000_000f, 32'hffff_ffff);
    rd(4'h3, 32'h0000_0004, 32'hffff_ffff);
  endtask
  task automatic t_run;
    crg_ttl_src_i.pulse(3'b101);
    wt(1'b1);
    chk(run_out, 1);
    crg_ttl_src_i.drive(3'b000);
    wt(1'b0);
    chk(run_out, 0);
    crg_ttl_src_i.drive(3'b100);
    wt(1'b1);
    crg_ttl_src_i.pulse(3'b110);
    wt(1'b0);
    crg_ttl_src_i.pulse(3'b101);
    wt(1'b1);
    wr(4'h0, 32'h0000_0002);
    wt(1'b0);
    crg_ttl_src_i.pulse(3'b111);
    stay(1'b0);
  endtask
  task automatic t_pol;
    wr(4'h1, 32'h0000_0007);
    stay(1'b0);
    chk(run_out, 1);
    wr(4'h1, 32'h0000_000f);
    crg_ttl_src_i.drive(3'b101);
    wr(4'h1, 32'h0000_000e);
    crg_ttl_src_i.drive(3'b100);
    wt(1'b1);
    crg_ttl_src_i.pulse(3'b110);
    wt(1'b0);
    wr(4'h1, 32'h0000_000f);
  endtask
  task automatic t_limit;
    wr(4'h6, 32'h0000_0003);
    wr(4'h0, 32'h0000_0005);
    wt(1'b1);
    crg_ttl_src_i.ticks(3);
    wt(1'b0);
    rd(4'h2, 32'h0000_0004, 32'h0000_0004);
    crg_ttl_src_i.pulse(3'b101);
    stay(1'b0);
    wr(4'h0, 32'h0000_0005);
    stay(1'b0);
    wr(4'h7, 32'h0000_0002);
    wr(4'h0, 32'h0000_0018);
    wr(4'h0, 32'h0000_0009);
    wt(1'b1);
    wt(1'b0);
    rd(4'h5, 32'h0000_0002, 32'hffff_ffff);
    wr(4'h0, 32'h0000_0010);
  endtask
  task automatic t_rows;
    wr(4'h3, 32'h0000_000e);
    #1 chk({row_lower_sel, row_upper_sel}, 4'he);
    rd(4'h8, 32'h0000_0003, 32'hffff_ffff);
    rd(4'h9, 32'h0000_0002, 32'hffff_ffff);
    rd(4'hf, 32'h0000_0000, 32'hffff_ffff);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_run();
    t_pol();
    t_limit();
    t_rows();
    final_report();
  end
  // whole run is a few hundred cycles
  initial begin
    #100000;
    fails++;
    final_report();
  end
endmodule
